// file: hdl/pmird_top.sv
// program memory indirect read path between core and program memory
`timescale 1ns/1ps
`default_nettype none
`include "pmird_defines.svh"

// Operation
// R01: pointer high byte bit 7 set routes indirect port reads to program memory.
// R02: indirect read of program memory loads only the low byte of the word.
// R03: indirect port writes never change program memory.
// R04: program memory access via pointer takes one extra instruction cycle.
// R05: remaining pointer bits below the select bit form the program word address.
module pmird_top
    import pmird_pkg::*;
#(
    parameter int PTR_W = `PMIRD_PTR_W,
    parameter int WORD_W = `PMIRD_WORD_W,
    parameter int DATA_W = `PMIRD_DATA_W
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [PTR_W-1:0] PTR,
    input wire logic RD_REQ,
    input wire logic WR_REQ,
    input wire logic [WORD_W-1:0] PM_DATA,
    input wire logic [DATA_W-1:0] DM_DATA,
    output logic [PTR_W-2:0] PM_ADDR,
    output logic PM_RD,
    output logic DM_RD,
    output logic DM_WR,
    output logic [DATA_W-1:0] RD_DATA,
    output logic RD_VALID,
    output logic STALL
);
    // the select bit sits at a fixed place in the high byte, so the pointer width is fixed
    if (PTR_W != 16 || DATA_W > WORD_W || DATA_W < 1) begin : g_bad_widths
        $error("pmird_top: unsupported widths");
    end

    pmird_state_t state;
    wire logic sel_pm;
    wire logic pm_read;
    wire logic dm_read;
    wire logic dm_write;

    assign sel_pm = PTR[`PMIRD_SEL_BIT + 8]; // R01
    assign pm_read = RD_REQ && sel_pm && state == PMIRD_IDLE; // R01
    assign dm_read = RD_REQ && !sel_pm && state == PMIRD_IDLE;
    // writes aimed at program memory are dropped; the core sees a normal finish
    assign dm_write = WR_REQ && !sel_pm && state == PMIRD_IDLE; // R03

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            state <= PMIRD_IDLE;
            PM_ADDR <= '0;
            PM_RD <= 1'b0;
            DM_RD <= 1'b0;
            DM_WR <= 1'b0;
            RD_DATA <= DATA_W'(`PMIRD_RST_DATA);
            RD_VALID <= 1'b0;
            STALL <= 1'b0;
        end else if (CE) begin
            DM_RD <= dm_read;
            DM_WR <= dm_write; // R03
            PM_RD <= 1'b0;
            RD_VALID <= 1'b0;
            case (state)
                PMIRD_IDLE: begin
                    if (pm_read) begin
                        PM_ADDR <= PTR[PTR_W-2:0]; // R05
                        PM_RD <= 1'b1;
                        STALL <= 1'b1; // R04
                        state <= PMIRD_FETCH;
                    end else if (dm_read) begin
                        state <= PMIRD_DONE;
                    end
                end
                PMIRD_FETCH: begin
                    // extra cycle spent while program memory answers
                    RD_DATA <= PM_DATA[DATA_W-1:0]; // R02
                    RD_VALID <= 1'b1; // R04
                    STALL <= 1'b0;
                    state <= PMIRD_IDLE;
                end
                PMIRD_DONE: begin
                    RD_DATA <= DM_DATA;
                    RD_VALID <= 1'b1;
                    state <= PMIRD_IDLE;
                end
                default: begin
                    state <= PMIRD_IDLE;
                end
            endcase
        end
    end
endmodule : pmird_top
`default_nettype wire

// file: hdl/pmird_defines.svh
// constants for the program memory indirect read path
`ifndef PMIRD_DEFINES_SVH
`define PMIRD_DEFINES_SVH
`define PMIRD_SEL_BIT 7
`define PMIRD_PTR_W 16
`define PMIRD_WORD_W 14
`define PMIRD_ADDR_W 15
`define PMIRD_DATA_W 8
`define PMIRD_EXTRA_CYC 1
`define PMIRD_RST_DATA 8'h00
`endif

// file: hdl/pmird_pkg.sv
// types for the program memory indirect read path
package pmird_pkg;
    typedef enum logic [1:0] {PMIRD_IDLE, PMIRD_FETCH, PMIRD_DONE} pmird_state_t;
endpackage : pmird_pkg

// file: sim/pmird_mem.sv
// memory model on the far side of the read path
`timescale 1ns/1ps
`default_nettype none
module pmird_mem (
    input wire logic PM_RD, DM_RD,
    input wire logic [14:0] PM_ADDR,
    output logic [13:0] PM_DATA,
    output logic [7:0] DM_DATA
);
    // idle lines show the inverse, so stale data cannot pass as a match
    assign PM_DATA = PM_RD ? {6'h2a, PM_ADDR[7:0] ^ 8'h5a} : ~PM_ADDR[13:0];
    assign DM_DATA = DM_RD ? 8'h3c : 8'hc3;
endmodule : pmird_mem
`default_nettype wire

// file: sim/pmird_sva.sv
// port assertions for the indirect read path
`timescale 1ns/1ps
`default_nettype none
module pmird_sva (
    input wire logic MCLK, NRST, CE, RD_REQ, WR_REQ, PM_RD, DM_RD, DM_WR, RD_VALID, STALL,
    input wire logic [15:0] PTR,
    input wire logic [13:0] PM_DATA,
    input wire logic [14:0] PM_ADDR,
    input wire logic [7:0] RD_DATA
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // a request in the cycle after a taken read is refused, so it is left out here
    sequence pm_take; CE && RD_REQ && PTR[15] && !PM_RD && !DM_RD; endsequence
    AST_ROUTE: assert property (pm_take |=> PM_RD && !DM_RD) else $error("route");
    AST_LOW: assert property (CE && PM_RD |=> RD_VALID && RD_DATA == $past(PM_DATA[7:0]))
        else $error("low byte");
    AST_NO_WR: assert property (CE && WR_REQ && PTR[15] |=> !DM_WR) else $error("wr");
    AST_EXTRA: assert property (pm_take |=> STALL ##1 !STALL) else $error("stall");
    AST_ADDR: assert property (pm_take |=> PM_ADDR == $past(PTR[14:0])) else $error("addr");
endmodule : pmird_sva
bind pmird_top pmird_sva pmird_sva_i (.*);
`default_nettype wire

// file: sim/tb_pmird_top.sv
// bench for the indirect read path
`timescale 1ns/1ps
`default_nettype none
module tb_pmird_top;
    logic MCLK = 0, NRST = 0, CE = 1, RD_REQ = 0, WR_REQ = 0;
    logic [15:0] PTR = 0;
    logic [13:0] PM_DATA;
    logic [14:0] PM_ADDR;
    logic [7:0] DM_DATA, RD_DATA;
    logic PM_RD, DM_RD, DM_WR, RD_VALID, STALL;
    int err_total = 0, total_checks = 0;
    logic [23:0] rows [3] = '{24'h80055f, 24'hffffa5, 24'h00123c};
    pmird_top pmird_top_i (.*);
    pmird_mem pmird_mem_i (.*);
    always #2.5 MCLK = ~MCLK;
    task chk(logic [8:0] g, e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task summarize;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        #5000;
        err_total++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge MCLK);
        NRST <= 1;
        foreach (rows[i]) begin
            @(posedge MCLK) PTR <= rows[i][23:8];
            RD_REQ <= 1;
            @(posedge MCLK) RD_REQ <= 0;
            #1 chk(STALL, PTR[15]);
            @(posedge MCLK) #1 chk({RD_VALID, RD_DATA}, {1'b1, rows[i][7:0]});
            @(posedge MCLK) #1 chk(STALL, 0);
        end
        @(posedge MCLK) PTR <= 16'h8001;
        WR_REQ <= 1;
        @(posedge MCLK) WR_REQ <= 0;
        #1 chk(DM_WR, 0);
        @(posedge MCLK) PTR <= 16'h0001;
        WR_REQ <= 1;
        @(posedge MCLK) WR_REQ <= 0;
        #1 chk(DM_WR, 1);
        summarize;
    end
endmodule : tb_pmird_top
`default_nettype wire
